// ===== logic/ikr_intc.sv
// interrupt controller with key return wake-up and register port
// Behaviour
// - non-maskable requests ignore enable, outrank all
// - any non-maskable or unmasked maskable request raises standby release
// - seven sources, two non-maskable, five maskable
// - maskable priority watchdog, timer a, b, lv, nvm
// - vectors 0002H key, 0004H watchdog, 0006H timer a
// - vectors 0008H timer b, 000AH lv, 000CH nvm
// - key falling edge requests only in stop
// - key inputs have no mask
// - one key low hides other key edges
// - watchdog overflow takes at most one path, none in stop or reset mode
// - flags set by source or write, cleared otherwise
// - flag register FFE0H, reset 00H, top bits zero
// - flags written singly or as whole byte
// - mask gates maskable only, never non-maskable
// - mask zero allows, one blocks, resets all ones
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module ikr_intc
  import ikr_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire ikr_bus_s      bus,
  output logic [7:0]         rd_data,
  input  wire ikr_src_s      srcs,
  input  wire ikr_wdt_mode_e wdt_mode,
  input  wire logic [3:0]    key_pin,
  input  wire logic          stop_mode,
  input  wire logic          global_maskable_enable,
  output logic               irq_req,
  output logic [15:0]        irq_vector,
  input  wire logic          irq_ack,
  output logic               standby_release,
  output logic               event_irq
);
  // =====================================================================
  // declarations
  logic               key_fall;
  logic               wdt_to_nmi;
  logic               wdt_to_msk;
  logic [NUM_MSK-1:0] src_set;
  logic [NUM_MSK-1:0] req_ff;
  logic [NUM_MSK-1:0] nxt_req;
  logic [NUM_MSK-1:0] mask_ff;
  logic [NUM_MSK-1:0] ack_clr;
  logic [NUM_MSK-1:0] live;
  logic [NUM_MSK-1:0] wbits;
  logic               key_pend_ff;
  logic               wnmi_pend_ff;
  logic [EVT_W-1:0]   estat_ff;
  logic [EVT_W-1:0]   emask_ff;
  logic [EVT_W-1:0]   evt_set;
  ikr_src_e           top;
  ikr_src_e           served_ff;
  logic [15:0]        vector_ff;
  logic [7:0]         rd_ff;
  logic [7:0]         nxt_rd;
  logic               wr_req;
  logic               wr_mask;
  logic               wr_estat;
  logic               wr_emask;

  // =====================================================================
  // key return detector
  ikr_key_detect #(
    .KEYS (KEY_N)
  ) u_key (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .key_pin   (key_pin),
    .stop_mode (stop_mode),
    .key_fall  (key_fall)
  );

  // =====================================================================
  // source routing
  // watchdog reset mode leaves both paths idle; the reset is elsewhere
  assign wdt_to_nmi = srcs.watchdog_overflow_irq && (wdt_mode == IKR_WDT_NMI);
  assign wdt_to_msk = srcs.watchdog_overflow_irq && (wdt_mode == IKR_WDT_INTERVAL);
  assign src_set = {srcs.nvm_write_done_irq, srcs.low_voltage_irq,
                    srcs.timer_b_match_irq, srcs.timer_a_match_irq,
                    wdt_to_msk};
  assign evt_set = {wdt_to_nmi, key_fall};

  // =====================================================================
  // write decode
  assign wr_req   = bus.wr && (bus.addr == ADR_REQ_FLAGS);
  assign wr_mask  = bus.wr && (bus.addr == ADR_MASK_FLAGS);
  assign wr_estat = bus.wr && (bus.addr == ADR_EVT_STAT);
  assign wr_emask = bus.wr && (bus.addr == ADR_EVT_MASK);
  assign wbits    = bus.wbits[NUM_MSK-1:0];

  // =====================================================================
  // acknowledge clears the served flag
  always_comb begin
    ack_clr = '0;
    if (irq_ack) begin
      unique case (served_ff)
        SRC_NONE: ack_clr = '0;
        SRC_KEY:  ack_clr = '0;
        SRC_WNMI: ack_clr = '0;
        SRC_WDT:  ack_clr[BIT_WDT] = 1'b1;
        SRC_TMA:  ack_clr[BIT_TMA] = 1'b1;
        SRC_TMB:  ack_clr[BIT_TMB] = 1'b1;
        SRC_LV:   ack_clr[BIT_LV] = 1'b1;
        SRC_NVM:  ack_clr[BIT_NVM] = 1'b1;
      endcase
    end
  end

  // =====================================================================
  // request flags: source set wins over write and acknowledge
  always_comb begin
    nxt_req = req_ff & ~ack_clr;
    if (wr_req) begin
      nxt_req = (nxt_req & ~wbits) | (bus.wdata[NUM_MSK-1:0] & wbits);
    end
    nxt_req = nxt_req | src_set;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff <= REQ_RESET[NUM_MSK-1:0];
    end else begin
      req_ff <= nxt_req;
    end
  end

  // =====================================================================
  // mask flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= MASK_RESET[NUM_MSK-1:0];
    end else if (wr_mask) begin
      mask_ff <= (mask_ff & ~wbits) | (bus.wdata[NUM_MSK-1:0] & wbits);
    end
  end

  // =====================================================================
  // non-maskable pending, no mask and no software clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_pend_ff <= 1'b0;
    end else if (key_fall) begin
      key_pend_ff <= 1'b1;
    end else if (irq_ack && served_ff == SRC_KEY) begin
      key_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wnmi_pend_ff <= 1'b0;
    end else if (wdt_to_nmi) begin
      wnmi_pend_ff <= 1'b1;
    end else if (irq_ack && served_ff == SRC_WNMI) begin
      wnmi_pend_ff <= 1'b0;
    end
  end

  // =====================================================================
  // event status and summary interrupt
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      estat_ff <= EVT_STAT_RESET;
    end else begin
      estat_ff <= (estat_ff & ~(wr_estat ? bus.wdata[EVT_W-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      emask_ff <= EVT_MASK_RESET;
    end else if (wr_emask) begin
      emask_ff <= bus.wdata[EVT_W-1:0];
    end
  end

  assign event_irq = |(estat_ff & ~emask_ff);

  // =====================================================================
  // priority resolution
  assign live = req_ff & ~mask_ff & {NUM_MSK{global_maskable_enable}};

  always_comb begin
    top = SRC_NONE;
    if (key_pend_ff) begin
      top = SRC_KEY;
    end else if (wnmi_pend_ff) begin
      top = SRC_WNMI;
    end else if (live[BIT_WDT]) begin
      top = SRC_WDT;
    end else if (live[BIT_TMA]) begin
      top = SRC_TMA;
    end else if (live[BIT_TMB]) begin
      top = SRC_TMB;
    end else if (live[BIT_LV]) begin
      top = SRC_LV;
    end else if (live[BIT_NVM]) begin
      top = SRC_NVM;
    end
  end

  // an acknowledge drops the request for one cycle so it is never taken twice
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      served_ff <= SRC_NONE;
      vector_ff <= VEC_NONE;
    end else if (irq_ack) begin
      served_ff <= SRC_NONE;
      vector_ff <= VEC_NONE;
    end else begin
      served_ff <= top;
      vector_ff <= ikr_vec(top);
    end
  end

  assign irq_req    = (served_ff != SRC_NONE);
  assign irq_vector = vector_ff;

  // enable is left out: a masked-off core must still wake
  assign standby_release = key_pend_ff || wnmi_pend_ff || (|(req_ff & ~mask_ff));

  // =====================================================================
  // read port, data valid only in the cycle after the strobe
  always_comb begin
    nxt_rd = RD_IDLE;
    unique case (bus.addr)
      ADR_REQ_FLAGS:  nxt_rd[NUM_MSK-1:0] = req_ff;
      ADR_MASK_FLAGS: nxt_rd = {MASK_FILL, mask_ff};
      ADR_EVT_STAT:   nxt_rd[EVT_W-1:0] = estat_ff;
      ADR_EVT_MASK:   nxt_rd[EVT_W-1:0] = emask_ff;
      ADR_PEND_SRC:   nxt_rd[2:0] = served_ff;
      default:        nxt_rd = RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ff <= RD_IDLE;
    end else begin
      rd_ff <= bus.rd ? nxt_rd : RD_IDLE;
    end
  end

  assign rd_data = rd_ff;

  // =====================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_key_in_stop;
    key_fall ##1 key_pend_ff;
  endsequence

  sequence s_flag_write_zero;
    wr_req && bus.wbits[BIT_TMA] && !bus.wdata[BIT_TMA] && !src_set[BIT_TMA];
  endsequence

  property p_key_sets;
    key_fall |-> s_key_in_stop;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("key edge lost");

  property p_key_only_stop;
    !stop_mode |=> !key_fall;
  endproperty
  a_key_only_stop: assert property (p_key_only_stop) else $error("key edge outside stop");

  property p_nmi_vector;
    key_pend_ff && !irq_ack |=> irq_req && (irq_vector == VEC_KEY);
  endproperty
  a_nmi_vector: assert property (p_nmi_vector) else $error("key nmi not first");

  property p_wnmi_no_enable;
    wnmi_pend_ff && !key_pend_ff && !global_maskable_enable && !irq_ack
      |=> irq_vector == VEC_WDT;
  endproperty
  a_wnmi_no_enable: assert property (p_wnmi_no_enable) else $error("wdt nmi gated");

  property p_standby;
    (key_pend_ff || wnmi_pend_ff || (|live)) |-> standby_release;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not released");

  property p_prio;
    live[BIT_TMA] && live[BIT_TMB] && !live[BIT_WDT] && !key_pend_ff
      && !wnmi_pend_ff && !irq_ack |=> irq_vector == VEC_TMA;
  endproperty
  a_prio: assert property (p_prio) else $error("timer a not preferred");

  property p_wdt_one_path;
    srcs.watchdog_overflow_irq && wdt_mode == IKR_WDT_NMI && !wr_req && !irq_ack
      |=> wnmi_pend_ff && (req_ff[BIT_WDT] == $past(req_ff[BIT_WDT]));
  endproperty
  a_wdt_one_path: assert property (p_wdt_one_path) else $error("wdt took two paths");

  property p_sw_clear;
    s_flag_write_zero |=> !req_ff[BIT_TMA];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag write zero kept");

  property p_read_flags;
    bus.rd && bus.addr == ADR_REQ_FLAGS |=> rd_data == {3'h0, $past(req_ff)};
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

  property p_masked_quiet;
    (&mask_ff) && !key_pend_ff && !wnmi_pend_ff ##1 (&mask_ff) && !key_pend_ff
      && !wnmi_pend_ff |-> !irq_req;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked request shown");
endmodule : ikr_intc

// ===== logic/ikr_pkg.sv
// shared constants and carrier types of the interrupt and key return block
package ikr_pkg;
  // =====================================================================
  // register map
  localparam int          ADDR_W         = 16;
  localparam logic [15:0] ADR_REQ_FLAGS  = 16'hFFE0;
  localparam logic [15:0] ADR_MASK_FLAGS = 16'hFFE4;
  localparam logic [15:0] ADR_EVT_STAT   = 16'hFFE8;
  localparam logic [15:0] ADR_EVT_MASK   = 16'hFFE9;
  localparam logic [15:0] ADR_PEND_SRC   = 16'hFFEA;
  localparam logic [7:0]  REQ_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'hFF;
  localparam logic [2:0]  MASK_FILL      = 3'h7;
  localparam logic [7:0]  RD_IDLE        = 8'h00;

  // =====================================================================
  // maskable flag layout
  localparam int NUM_MSK = 5;
  localparam int BIT_WDT = 0;
  localparam int BIT_TMA = 1;
  localparam int BIT_TMB = 2;
  localparam int BIT_LV  = 3;
  localparam int BIT_NVM = 4;

  // =====================================================================
  // event status for the summary interrupt
  localparam int         EVT_W          = 2;
  localparam int         EVT_KEY        = 0;
  localparam int         EVT_WDT        = 1;
  localparam logic [1:0] EVT_STAT_RESET = 2'h0;
  localparam logic [1:0] EVT_MASK_RESET = 2'h3;

  // =====================================================================
  // vectors
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_KEY  = 16'h0002;
  localparam logic [15:0] VEC_WDT  = 16'h0004;
  localparam logic [15:0] VEC_TMA  = 16'h0006;
  localparam logic [15:0] VEC_TMB  = 16'h0008;
  localparam logic [15:0] VEC_LV   = 16'h000A;
  localparam logic [15:0] VEC_NVM  = 16'h000C;

  // =====================================================================
  // key inputs
  localparam int         KEY_N    = 4;
  localparam logic [3:0] KEY_IDLE = 4'hF;

  typedef enum logic [1:0] {
    IKR_WDT_STOP     = 2'h0,
    IKR_WDT_INTERVAL = 2'h1,
    IKR_WDT_NMI      = 2'h2,
    IKR_WDT_RESET    = 2'h3
  } ikr_wdt_mode_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_KEY  = 3'h1,
    SRC_WNMI = 3'h2,
    SRC_WDT  = 3'h3,
    SRC_TMA  = 3'h4,
    SRC_TMB  = 3'h5,
    SRC_LV   = 3'h6,
    SRC_NVM  = 3'h7
  } ikr_src_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wbits;
    logic        wr;
    logic        rd;
  } ikr_bus_s;

  typedef struct packed {
    logic nvm_write_done_irq;
    logic low_voltage_irq;
    logic timer_b_match_irq;
    logic timer_a_match_irq;
    logic watchdog_overflow_irq;
  } ikr_src_s;

  function automatic logic [15:0] ikr_vec(input ikr_src_e s);
    logic [15:0] v;
    v = VEC_NONE;
    unique case (s)
      SRC_NONE: v = VEC_NONE;
      SRC_KEY:  v = VEC_KEY;
      SRC_WNMI: v = VEC_WDT;
      SRC_WDT:  v = VEC_WDT;
      SRC_TMA:  v = VEC_TMA;
      SRC_TMB:  v = VEC_TMB;
      SRC_LV:   v = VEC_LV;
      SRC_NVM:  v = VEC_NVM;
    endcase
    return v;
  endfunction : ikr_vec
endpackage : ikr_pkg

// ===== logic/ikr_key_detect.sv
// key return falling edge detector with pin synchronisers
`timescale 1ns/1ps
module ikr_key_detect
  import ikr_pkg::*;
#(
  parameter int KEYS = KEY_N
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [KEYS-1:0] key_pin,
  input  wire logic            stop_mode,
  output logic                 key_fall
);
  // =====================================================================
  // three-stage sync, level accepted once stages two and three agree
  logic [KEYS-1:0] s1_ff;
  logic [KEYS-1:0] s2_ff;
  logic [KEYS-1:0] s3_ff;
  logic [KEYS-1:0] level_ff;
  logic [KEYS-1:0] agree;
  logic            all_high_ff;
  logic            fall_ff;

  // idle high so release of reset never fakes an edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= {KEYS{1'b1}};
      s2_ff <= {KEYS{1'b1}};
      s3_ff <= {KEYS{1'b1}};
    end else begin
      s1_ff <= key_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign agree = ~(s2_ff ^ s3_ff);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_ff <= {KEYS{1'b1}};
    end else begin
      level_ff <= (level_ff & ~agree) | (s3_ff & agree);
    end
  end

  // =====================================================================
  // edge of the combined inputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      all_high_ff <= 1'b1;
      fall_ff     <= 1'b0;
    end else begin
      all_high_ff <= &level_ff;
      fall_ff     <= stop_mode && all_high_ff && !(&level_ff);
    end
  end

  assign key_fall = fall_ff;
endmodule : ikr_key_detect

// ===== tb/ikr_core_model.sv
// behavioural cpu core that acknowledges interrupt requests
`timescale 1ns/1ps
module ikr_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       irq_req,
  input  wire logic       want_ie,
  input  wire logic [3:0] ack_wait,
  output logic            irq_ack,
  output logic            gme_ff
);
  // =====================================================================
  // acknowledge after a programmable wait, prompt or slow
  logic [3:0] wait_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      wait_ff <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      // no second pulse while the taken request is still dropping
      if (!irq_req || irq_ack) begin
        wait_ff <= 4'h0;
      end else if (wait_ff == ack_wait) begin
        irq_ack <= 1'b1;
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end

  // =====================================================================
  // enable drops on every acknowledge, then follows software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gme_ff <= 1'b0;
    end else begin
      gme_ff <= irq_ack ? 1'b0 : want_ie;
    end
  end
endmodule : ikr_core_model

// ===== tb/ikr_intc_tb.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
module ikr_intc_tb;
  import ikr_pkg::*;
  logic          sys_clk;
  logic          rst_b;
  ikr_bus_s      bus;
  logic [7:0]    rd_data;
  ikr_src_s      srcs;
  ikr_wdt_mode_e wdt_mode;
  logic [3:0]    key_pin;
  logic          stop_mode;
  logic          gme_ff;
  logic          irq_req;
  logic [15:0]   irq_vector;
  logic          irq_ack;
  logic          standby_release;
  logic          event_irq;
  logic          want_ie;
  logic [3:0]    ack_wait;
  logic [15:0]   seen_q[$];
  int            n_mismatch;
  int            num_checks;

  ikr_intc ikr_intc_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
    .srcs(srcs), .wdt_mode(wdt_mode), .key_pin(key_pin), .stop_mode(stop_mode),
    .global_maskable_enable(gme_ff), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .standby_release(standby_release), .event_irq(event_irq));

  ikr_core_model ikr_core_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .irq_req(irq_req),
    .want_ie(want_ie), .ack_wait(ack_wait), .irq_ack(irq_ack), .gme_ff(gme_ff));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // vector in force at each acknowledge edge
  always @(posedge sys_clk) if (irq_ack) seen_q.push_back(irq_vector);

  // =====================================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    bus <= {a, d, m, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk("read data", {8'h00, exp}, {8'h00, rd_data});
    @(posedge sys_clk);
  endtask : rd

  task automatic pulse(input ikr_src_s s);
    srcs <= s;
    @(posedge sys_clk);
    srcs <= '0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse

  task automatic acks(input logic [15:0] ev[$]);
    int i;
    for (i = 0; i < 300 && seen_q.size() < ev.size(); i++) @(posedge sys_clk);
    if (seen_q.size() < ev.size()) begin
      n_mismatch++;
      $display("CHECK FAILED ack count expected %0d seen %0d", ev.size(), seen_q.size());
      tally_and_finish();
    end
    foreach (ev[k]) chk("vector", ev[k], seen_q[k]);
    seen_q.delete();
  endtask : acks

  task automatic none_for(input int n);
    repeat (n) @(posedge sys_clk);
    chk("quiet", 16'h0000, 16'(seen_q.size()));
  endtask : none_for

  // =====================================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    bus = '0;
    srcs = '0;
    wdt_mode = IKR_WDT_INTERVAL;
    key_pin = KEY_IDLE;
    stop_mode = 1'b0;
    want_ie = 1'b0;
    ack_wait = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(ADR_REQ_FLAGS, 8'h00);
    rd(ADR_MASK_FLAGS, 8'hFF);
    rd(16'hFFF0, 8'h00);
    rd(ADR_EVT_MASK, 8'h03);
    rd(ADR_PEND_SRC, 8'h00);
    wr(ADR_REQ_FLAGS, 8'hFF, 8'hFF);
    rd(ADR_REQ_FLAGS, 8'h1F);
    wr(ADR_REQ_FLAGS, 8'h00, 8'h04);
    rd(ADR_REQ_FLAGS, 8'h1B);
    wr(ADR_REQ_FLAGS, 8'h00, 8'hFF);
    rd(ADR_REQ_FLAGS, 8'h00);
    // all five sources pending while masked and disabled
    pulse(5'h1F);
    rd(ADR_REQ_FLAGS, 8'h1F);
    chk("standby masked", 16'h0000, {15'h0000, standby_release});
    wr(ADR_MASK_FLAGS, 8'h1D, 8'hFF);
    chk("standby", 16'h0001, {15'h0000, standby_release});
    none_for(10);
    ack_wait <= 4'h5;
    want_ie <= 1'b1;
    acks('{VEC_TMA});
    wr(ADR_MASK_FLAGS, 8'h00, 8'hFF);
    acks('{VEC_WDT, VEC_TMB, VEC_LV, VEC_NVM});
    rd(ADR_REQ_FLAGS, 8'h00);
    // key return against a pending maskable request
    want_ie <= 1'b0;
    ack_wait <= 4'h0;
    pulse(5'h02);
    key_pin <= 4'hE;
    none_for(20);
    key_pin <= KEY_IDLE;
    stop_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    key_pin <= 4'hB;
    acks('{VEC_KEY});
    key_pin <= 4'h9;
    none_for(20);
    key_pin <= KEY_IDLE;
    repeat (8) @(posedge sys_clk);
    want_ie <= 1'b1;
    acks('{VEC_TMA});
    // watchdog overflow on the non-maskable path
    want_ie <= 1'b0;
    stop_mode <= 1'b0;
    wdt_mode <= IKR_WDT_NMI;
    wr(ADR_MASK_FLAGS, 8'hFF, 8'hFF);
    pulse(5'h01);
    acks('{VEC_WDT});
    rd(ADR_REQ_FLAGS, 8'h00);
    // reset mode: the overflow raises nothing on either path
    wdt_mode <= IKR_WDT_RESET;
    pulse(5'h01);
    none_for(10);
    rd(ADR_REQ_FLAGS, 8'h00);
    // summary interrupt from the two non-maskable events
    rd(ADR_EVT_STAT, 8'h03);
    chk("event masked", 16'h0000, {15'h0000, event_irq});
    wr(ADR_EVT_MASK, 8'h00, 8'hFF);
    chk("event irq", 16'h0001, {15'h0000, event_irq});
    wr(ADR_EVT_STAT, 8'h03, 8'hFF);
    chk("event cleared", 16'h0000, {15'h0000, event_irq});
    tally_and_finish();
  end
endmodule : ikr_intc_tb
